// [dv/ppcs_printer.sv]
// Printer model: takes a byte on each strobe fall, then busy and ack.
// Assumes pins are sampled on the bench clock.
`timescale 1ns/10ps
module ppcs_printer (
  // Clock and bench commands
  input  wire logic       aclk,
  input  wire logic       nopap_cmd,
  input  wire logic       fault_cmd,
  // Port pins
  input  wire logic       strobe_n,
  input  wire logic       feed_n,
  input  wire logic [7:0] data,
  output logic            busy,
  output logic            ack_n,
  output logic            nopap,
  output logic            online,
  output logic            fault_n,
  output logic [7:0]      got,
  output logic            feed
);
  int   cnt      = 0;
  logic strobe_q = 1'h1;
  assign nopap   = nopap_cmd;
  assign fault_n = !fault_cmd;
  assign online  = 1'h1;
  assign feed    = !feed_n;
  assign busy    = cnt != 0;
  assign ack_n   = !(cnt inside {[1:4]});
  always @(posedge aclk) begin
    strobe_q <= strobe_n;
    if (strobe_q && !strobe_n) begin
      got <= data;
      cnt <= 20;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule : ppcs_printer

// [dv/printer_port_control_status_tb.sv]
// Bench for the printer port block with a printer model.
// Assumes a 100 MHz clock and the bench as sole bus master.
`timescale 1ns/10ps
module printer_port_control_status_tb;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic [3:0]  wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        stb_n, feed_n, init_n, choose_n, feed;
  logic        busy, ack_n, nopap, online, fault_n;
  logic        nopap_cmd = 1'h0, fault_cmd = 1'h0;
  logic [7:0]  pdata, poe, got;
  int          n_fail = 0, check_count = 0, cyc = 0;
  always #5 aclk = ~aclk;
  ppcs_port i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .byte_strobe_out_n(stb_n),
    .line_advance_out_n(feed_n), .printer_init_out_n(init_n),
    .printer_choose_out_n(choose_n), .printer_busy_in(busy),
    .printer_received_n(ack_n), .no_media_in(nopap),
    .printer_online_in(online), .printer_fault_in_n(fault_n),
    .port_byte_out(pdata), .port_byte_oe(poe), .irq(irq));
  ppcs_printer i_prn (.aclk(aclk), .nopap_cmd(nopap_cmd),
    .fault_cmd(fault_cmd), .strobe_n(stb_n), .feed_n(feed_n), .data(pdata),
    .busy(busy), .ack_n(ack_n), .nopap(nopap), .online(online),
    .fault_n(fault_n), .got(got), .feed(feed));
  task automatic summarize;
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        w = 1'h1;
        wvalid <= 1'h0;
      end
    end
    bready <= 1'h1;
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk(32'(bresp), 32'(ppcs_pkg::RESP_OKAY));
    #1;
  endtask : wr
  task automatic rdr(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    rready <= 1'h1;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rd = rdata;
    chk(32'(rresp), 32'(ppcs_pkg::RESP_OKAY));
    rready <= 1'h0;
  endtask : rdr
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rdr(ppcs_pkg::OFF_CONTROL);
    chk(rd, 32'(ppcs_pkg::CTL_RESET));
    rdr(ppcs_pkg::OFF_IRQ_ST);
    chk(rd, 32'h0);
    for (int v = 0; v < 16; v++) begin
      wr(ppcs_pkg::OFF_CONTROL, 32'(v));
      chk(stb_n, !v[0]);
      chk(feed_n, !v[1]);
      chk(init_n, v[2]);
      chk(choose_n, !v[3]);
      chk(feed, v[1]);
      rdr(ppcs_pkg::OFF_CONTROL);
      chk(rd, 32'(v));
    end
    wr(ppcs_pkg::OFF_CONTROL, 32'h4);
    repeat (30) @(posedge aclk);
    wr(ppcs_pkg::OFF_IRQ_ST, 32'h7);
    wr(ppcs_pkg::OFF_IRQ_MSK, 32'h7);
    rdr(ppcs_pkg::OFF_IRQ_MSK);
    chk(rd, 32'h7);
    rdr(ppcs_pkg::OFF_STATUS);
    chk(rd & 32'hf8, 32'hd8);
    @(posedge aclk);
    nopap_cmd <= 1'h1;
    fault_cmd <= 1'h1;
    repeat (5) @(posedge aclk);
    rdr(ppcs_pkg::OFF_STATUS);
    chk(rd & 32'hf8, 32'hf0);
    rdr(ppcs_pkg::OFF_IRQ_ST);
    chk(rd & 32'h7, 32'h6);
    chk(irq, 1'h1);
    wr(ppcs_pkg::OFF_IRQ_ST, 32'h2);
    rdr(ppcs_pkg::OFF_IRQ_ST);
    chk(rd & 32'h7, 32'h4);
    wr(ppcs_pkg::OFF_IRQ_ST, 32'h4);
    chk(irq, 1'h0);
    wr(ppcs_pkg::OFF_DATA, 32'ha5);
    chk(pdata, 8'ha5);
    chk(poe, 8'hff);
    @(posedge aclk);
    wstrb <= 4'h0;
    wr(ppcs_pkg::OFF_DATA, 32'h3c);
    chk(pdata, 8'ha5);
    @(posedge aclk);
    wstrb <= 4'hf;
    wr(ppcs_pkg::OFF_CONTROL, 32'h5);
    chk(stb_n, 1'h0);
    wr(ppcs_pkg::OFF_CONTROL, 32'h4);
    rdr(ppcs_pkg::OFF_STATUS);
    chk(rd[7], 1'h0);
    chk(got, 8'ha5);
    repeat (30) @(posedge aclk);
    rdr(ppcs_pkg::OFF_IRQ_ST);
    chk(rd & 32'h7, 32'h1);
    summarize();
  end
endmodule : printer_port_control_status_tb

// [verilog/ppcs_pkg.sv]
// Package for the printer port control and status block.
// Assumes a 32-bit AXI4-Lite register bus; word-aligned byte addresses.
package ppcs_pkg;
  // Register byte addresses.
  localparam logic [4:0] OFF_DATA    = 5'h00;
  localparam logic [4:0] OFF_CONTROL = 5'h04;
  localparam logic [4:0] OFF_STATUS  = 5'h08;
  localparam logic [4:0] OFF_IRQ_ST  = 5'h0c;
  localparam logic [4:0] OFF_IRQ_MSK = 5'h10;
  // Control field positions.
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT   = 2;
  localparam int CTL_SELECT = 3;
  // Status field positions.
  localparam int ST_BUSY   = 7;
  localparam int ST_ACK    = 6;
  localparam int ST_NOPAP  = 5;
  localparam int ST_ONLINE = 4;
  localparam int ST_FAULT  = 3;
  // Interrupt event positions.
  localparam int EV_ACK   = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_NOPAP = 2;
  localparam int EV_W     = 3;
  // Reset values: control 0x04 keeps init line high (printer not reset).
  localparam logic [7:0] CTL_RESET  = 8'h04;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ppcs_pkg

// [verilog/ppcs_port.sv]
// Printer parallel port, standard mode: control, status and data lines.
// Notes on behaviour
// RULE1: The strobe line is the inverse of control bit 0.
// RULE2: The auto line feed line is the inverse of control bit 1.
// RULE3: The initialize line equals control bit 2, so a low resets the printer.
// RULE4: The select line is the inverse of control bit 3.
// RULE5: Status bit 7 reads the inverse of the synchronised busy input.
// RULE6: Status bit 6 reads the acknowledge input as sampled.
// RULE7: Status bit 5 reads the paper-out input as sampled.
// RULE8: Status bit 4 reads the printer-online input as sampled.
// RULE9: Status bit 3 reads the fault input as sampled.
// RULE10: Software pulses the strobe low by setting then clearing bit 0.
// RULE11: The printer holds busy high while it cannot take a byte.
// RULE12: The printer pulses acknowledge low when it took the byte.
// RULE13: The printer drives paper-out high when it has no paper.
// RULE14: The printer drives online high when powered on.
// RULE15: The printer drives fault low while it has an error.
// RULE16: While auto line feed is low the printer feeds a line per line.
// RULE17: The data lines show the byte last written to the data register.
// Assumes an AXI4-Lite master on aclk; printer pins are asynchronous.
`timescale 1ns/10ps
module ppcs_port (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [4:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [4:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Printer control outputs
  output logic             byte_strobe_out_n,
  output logic             line_advance_out_n,
  output logic             printer_init_out_n,
  output logic             printer_choose_out_n,
  // Printer status inputs
  input  wire logic        printer_busy_in,
  input  wire logic        printer_received_n,
  input  wire logic        no_media_in,
  input  wire logic        printer_online_in,
  input  wire logic        printer_fault_in_n,
  // Port data lines
  output logic [7:0]       port_byte_out,
  output logic [7:0]       port_byte_oe,
  // Interrupt
  output logic             irq
);

  // Pin inputs through two flops.
  logic [4:0] pins_s;
  ppcs_sync #(.W(5)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .async_i ({printer_busy_in, printer_received_n, no_media_in,
               printer_online_in, printer_fault_in_n}),
    .sync_o  (pins_s)
  );
  logic busy_s, ack_s, nopap_s, online_s, fault_s;
  assign busy_s   = pins_s[4];
  assign ack_s    = pins_s[3];
  assign nopap_s  = pins_s[2];
  assign online_s = pins_s[1];
  assign fault_s  = pins_s[0];

  // Status byte; reserved bits 2..0 read as zero.
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[ppcs_pkg::ST_BUSY]   = ~busy_s;   // see RULE5
    status[ppcs_pkg::ST_ACK]    = ack_s;     // see RULE6
    status[ppcs_pkg::ST_NOPAP]  = nopap_s;   // see RULE7
    status[ppcs_pkg::ST_ONLINE] = online_s;  // see RULE8
    status[ppcs_pkg::ST_FAULT]  = fault_s;   // see RULE9
  end

  // Bus and register state.
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [4:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [7:0]  ctl_q, ctl_d, dat_q, dat_d;
  logic [2:0]  ist_q, ist_d, imsk_q, imsk_d;
  logic        ack_q, ack_d, flt_q, flt_d, pap_q, pap_d;
  logic        wr_go;
  logic [2:0]  ev;

  assign s_axi_awready = ~aw_q & ~b_q;
  assign s_axi_wready  = ~w_q & ~b_q;
  assign s_axi_arready = ~r_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign wr_go = aw_q & w_q & ~b_q;

  // Events: acknowledge falling, fault falling, paper-out rising.
  assign ev[ppcs_pkg::EV_ACK]   = ack_q & ~ack_s;
  assign ev[ppcs_pkg::EV_FAULT] = flt_q & ~fault_s;
  assign ev[ppcs_pkg::EV_NOPAP] = ~pap_q & nopap_s;

  always_comb begin
    aw_d = aw_q; awa_d = awa_q; w_d = w_q; wd_d = wd_q; ws_d = ws_q;
    b_d = b_q; br_d = br_q; r_d = r_q; rd_d = rd_q; rr_d = rr_q;
    ctl_d = ctl_q; dat_d = dat_q; imsk_d = imsk_q;
    ack_d = ack_s; flt_d = fault_s; pap_d = nopap_s;
    ist_d = ist_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      b_d  = 1'b1;
      br_d = ppcs_pkg::RESP_OKAY;
      unique case ({awa_q[4:2], 2'b00})
        ppcs_pkg::OFF_DATA:
          if (ws_q[0]) dat_d = wd_q[7:0];                  // see RULE17
        ppcs_pkg::OFF_CONTROL:
          if (ws_q[0]) ctl_d = {4'h0, wd_q[3:0]};          // see RULE10
        ppcs_pkg::OFF_STATUS: ;
        ppcs_pkg::OFF_IRQ_ST:
          if (ws_q[0]) ist_d = ist_q & ~wd_q[2:0];
        ppcs_pkg::OFF_IRQ_MSK:
          if (ws_q[0]) imsk_d = wd_q[2:0];
        default: ;
      endcase
    end
    // Set wins over a same-cycle write-one-to-clear.
    ist_d = ist_d | ev;
    if (b_q && s_axi_bready) b_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      r_d  = 1'b1;
      rr_d = ppcs_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[4:2], 2'b00})
        ppcs_pkg::OFF_DATA:    rd_d = {24'h0, dat_q};
        ppcs_pkg::OFF_CONTROL: rd_d = {24'h0, ctl_q};
        ppcs_pkg::OFF_STATUS:  rd_d = {24'h0, status};
        ppcs_pkg::OFF_IRQ_ST:  rd_d = {29'h0, ist_q};
        ppcs_pkg::OFF_IRQ_MSK: rd_d = {29'h0, imsk_q};
        default:               rd_d = 32'h0;
      endcase
    end
    if (r_q && s_axi_rready) r_d = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
      awa_q <= 5'h00; wd_q <= 32'h0; ws_q <= 4'h0;
      br_q <= 2'h0; rd_q <= 32'h0; rr_q <= 2'h0;
      ctl_q <= ppcs_pkg::CTL_RESET;
      dat_q <= ppcs_pkg::DATA_RESET;
      ist_q <= 3'h0; imsk_q <= 3'h0;
      // Detectors start at the synchroniser's reset level, so the rise of
      // the synchronised idle-high pins after reset is not taken as an edge.
      ack_q <= 1'b0; flt_q <= 1'b0; pap_q <= 1'b0;
    end else begin
      aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
      awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d;
      br_q <= br_d; rd_q <= rd_d; rr_q <= rr_d;
      ctl_q <= ctl_d; dat_q <= dat_d;
      ist_q <= ist_d; imsk_q <= imsk_d;
      ack_q <= ack_d; flt_q <= flt_d; pap_q <= pap_d;
    end
  end

  assign byte_strobe_out_n    = ~ctl_q[ppcs_pkg::CTL_STROBE]; // see RULE1
  assign line_advance_out_n   = ~ctl_q[ppcs_pkg::CTL_AUTOFD]; // see RULE2
  assign printer_init_out_n   = ctl_q[ppcs_pkg::CTL_INIT];    // see RULE3
  assign printer_choose_out_n = ~ctl_q[ppcs_pkg::CTL_SELECT]; // see RULE4
  assign port_byte_out        = dat_q;                        // see RULE17
  assign port_byte_oe         = 8'hff;
  assign irq                  = |(ist_q & imsk_q);

  // A write to a register that drives lines, as applied by the bus logic.
  sequence s_ctl_wr;
    wr_go && ({awa_q[4:2], 2'b00} == ppcs_pkg::OFF_CONTROL) && ws_q[0];
  endsequence

  sequence s_dat_wr;
    wr_go && ({awa_q[4:2], 2'b00} == ppcs_pkg::OFF_DATA) && ws_q[0];
  endsequence

  // Pins reach the status byte two edges late, once reset has been off.
  sequence s_pins_live;
    $past(aresetn) && $past(aresetn, 2);
  endsequence

  property p_strobe_follows;
    @(posedge aclk) disable iff (!aresetn)
      s_ctl_wr |=> byte_strobe_out_n == ~$past(wd_q[ppcs_pkg::CTL_STROBE]);
  endproperty
  a_strobe_follows: assert property (p_strobe_follows) // see RULE1
    else $error("Strobe line does not follow control bit 0.");

  property p_autofd_follows;
    @(posedge aclk) disable iff (!aresetn)
      s_ctl_wr |=> line_advance_out_n == ~$past(wd_q[ppcs_pkg::CTL_AUTOFD]);
  endproperty
  a_autofd_follows: assert property (p_autofd_follows) // see RULE2
    else $error("Line feed line does not follow control bit 1.");

  property p_init_follows;
    @(posedge aclk) disable iff (!aresetn)
      s_ctl_wr |=> printer_init_out_n == $past(wd_q[ppcs_pkg::CTL_INIT]);
  endproperty
  a_init_follows: assert property (p_init_follows) // see RULE3
    else $error("Initialize line does not follow control bit 2.");

  property p_select_follows;
    @(posedge aclk) disable iff (!aresetn)
      s_ctl_wr |=> printer_choose_out_n == ~$past(wd_q[ppcs_pkg::CTL_SELECT]);
  endproperty
  a_select_follows: assert property (p_select_follows) // see RULE4
    else $error("Select line does not follow control bit 3.");

  property p_data_follows;
    @(posedge aclk) disable iff (!aresetn)
      s_dat_wr |=> port_byte_out == $past(wd_q[7:0]);
  endproperty
  a_data_follows: assert property (p_data_follows) // see RULE17
    else $error("Port data lines do not show the written byte.");

  property p_busy_status;
    @(posedge aclk) disable iff (!aresetn)
      s_pins_live |->
        status[ppcs_pkg::ST_BUSY] == ~$past(printer_busy_in, 2);
  endproperty
  a_busy_status: assert property (p_busy_status) // see RULE5
    else $error("Busy status bit is not the inverse of the pin.");

  property p_ack_status;
    @(posedge aclk) disable iff (!aresetn)
      s_pins_live |->
        status[ppcs_pkg::ST_ACK] == $past(printer_received_n, 2);
  endproperty
  a_ack_status: assert property (p_ack_status) // see RULE6
    else $error("Acknowledge status bit does not match the pin.");

  property p_nopap_status;
    @(posedge aclk) disable iff (!aresetn)
      s_pins_live |->
        status[ppcs_pkg::ST_NOPAP] == $past(no_media_in, 2);
  endproperty
  a_nopap_status: assert property (p_nopap_status) // see RULE7
    else $error("Paper-out status bit does not match the pin.");

  property p_online_status;
    @(posedge aclk) disable iff (!aresetn)
      s_pins_live |->
        status[ppcs_pkg::ST_ONLINE] == $past(printer_online_in, 2);
  endproperty
  a_online_status: assert property (p_online_status) // see RULE8
    else $error("Online status bit does not match the pin.");

  property p_fault_status;
    @(posedge aclk) disable iff (!aresetn)
      s_pins_live |->
        status[ppcs_pkg::ST_FAULT] == $past(printer_fault_in_n, 2);
  endproperty
  a_fault_status: assert property (p_fault_status) // see RULE9
    else $error("Fault status bit does not match the pin.");

  // The strobe only moves when software writes, never by itself.
  property p_strobe_by_write;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $changed(byte_strobe_out_n) |-> $past(wr_go);
  endproperty
  a_strobe_by_write: assert property (p_strobe_by_write) // see RULE10
    else $error("Strobe line moved without a register write.");

  property p_data_by_write;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $changed(port_byte_out) |-> $past(wr_go);
  endproperty
  a_data_by_write: assert property (p_data_by_write) // see RULE17
    else $error("Port data lines moved without a register write.");

  // A pin event is latched even when a clear lands in the same cycle.
  property p_event_sticky;
    @(posedge aclk) disable iff (!aresetn)
      |ev |=> (ist_q & $past(ev)) == $past(ev);
  endproperty
  a_event_sticky: assert property (p_event_sticky) // see RULE12
    else $error("A pin event was not latched in the event status.");
endmodule : ppcs_port

// [verilog/ppcs_sync.sv]
// Two-flop synchroniser for a bank of pin inputs.
// Assumes inputs are asynchronous to aclk.
`timescale 1ns/10ps
module ppcs_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule : ppcs_sync
